/* File: hdl/eii_channel.sv */
`default_nettype none
module eii_channel #(
  parameter int unsigned NUM_INPUTS = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_INPUTS-1:0] fieldInputs,
  input wire logic [15:0] cfgInputSelect,
  input wire logic cfgAutoStart,
  input wire logic execMode,
  input wire logic enableSet,
  input wire logic enableClear,
  input wire logic unitDone,
  input wire logic lostWrite,
  input wire logic lostWriteData,
  output logic unitStart,
  output logic [15:0] inputSelectWord,
  output eii_pkg::eii_status_t status
);
  import eii_pkg::*;

  // ----------------------------------------
  // Configuration capture and input select
  // ----------------------------------------
  localparam int unsigned TOP_SEL =
    (NUM_INPUTS - 1 < EII_MAX_SEL) ? NUM_INPUTS - 1 : EII_MAX_SEL;

  function automatic logic [3:0] clampSel(input logic [15:0] raw);
    if (raw > 16'(TOP_SEL)) clampSel = 4'(TOP_SEL);
    else clampSel = raw[3:0];
  endfunction : clampSel

  logic [3:0] sel_q, sel_d;
  logic autoStart_q, autoStart_d;
  logic cfgLoaded_q, cfgLoaded_d;

  // Config latched once after reset; program has no write path
  always_comb begin
    sel_d = sel_q;
    autoStart_d = autoStart_q;
    cfgLoaded_d = 1'b1;
    if (!cfgLoaded_q) begin
      sel_d = clampSel(cfgInputSelect); // RQ2
      autoStart_d = cfgAutoStart; // RQ3
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= EII_SEL_RESET;
      autoStart_q <= EII_FLAG_RESET;
      cfgLoaded_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      autoStart_q <= autoStart_d;
      cfgLoaded_q <= cfgLoaded_d;
    end
  end

  // ----------------------------------------
  // Input synchroniser and edge detect
  // ----------------------------------------
  logic [NUM_INPUTS-1:0] meta_q, sync_q;
  logic last_q, last_d;
  logic selLevel, event_w;

  // Two-flop synchroniser for the field pins
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= fieldInputs;
      sync_q <= meta_q;
    end
  end

  // Rising edge of the selected input is the event
  always_comb begin
    selLevel = sync_q[sel_q]; // RQ2
    last_d = selLevel;
    event_w = selLevel && !last_q && cfgLoaded_q;
  end

  // Previous level of the selected input
  always_ff @(posedge clk) begin
    if (rst) last_q <= 1'b0;
    else last_q <= last_d;
  end

  // ----------------------------------------
  // Enable, request queue and lost flag
  // ----------------------------------------
  eii_state_t state_q, state_d;
  logic enable_q, enable_d;
  logic lost_q, lost_d;
  logic execMode_q;
  logic start_d, start_q;
  logic req;

  // Enable control, request queue and lost flag next values
  always_comb begin
    enable_d = enable_q;
    if (enableClear) enable_d = 1'b0;
    if (enableSet) enable_d = 1'b1;
    if (execMode && !execMode_q && autoStart_q) enable_d = 1'b1; // RQ1
    req = event_w && enable_q;
    state_d = state_q;
    start_d = 1'b0;
    lost_d = lost_q;
    // Program may only clear lost; a written one is ignored
    if (lostWrite && !lostWriteData) lost_d = 1'b0; // RQ7
    unique case (state_q)
      EII_IDLE: begin
        if (req) begin
          state_d = EII_ACTIVE; // RQ4
          start_d = 1'b1;
        end
      end
      EII_ACTIVE: begin
        if (unitDone && req) start_d = 1'b1;
        else if (unitDone) state_d = EII_IDLE; // RQ5
        else if (req) state_d = EII_QUEUED; // RQ8
      end
      EII_QUEUED: begin
        if (unitDone) begin
          state_d = EII_ACTIVE; // RQ10
          start_d = 1'b1;
        end
        if (req && !unitDone) lost_d = 1'b1; // RQ6
        if (req && unitDone) state_d = EII_QUEUED;
      end
      default: state_d = EII_IDLE;
    endcase
  end

  // Queue state, enable and lost registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= EII_IDLE;
      enable_q <= EII_FLAG_RESET;
      lost_q <= EII_FLAG_RESET;
      execMode_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      enable_q <= enable_d;
      lost_q <= lost_d;
      execMode_q <= execMode;
      start_q <= start_d;
    end
  end

  // ----------------------------------------
  // Program-visible outputs
  // ----------------------------------------
  // Status fields all read only except lost
  always_comb begin
    unitStart = start_q;
    inputSelectWord = {12'h000, sel_q}; // RQ3
    status.autoStart = autoStart_q;
    status.channelEnable = enable_q; // RQ9
    status.inService = (state_q != EII_IDLE); // RQ4
    status.queued = (state_q == EII_QUEUED); // RQ8
    status.lost = lost_q;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Checks guard the queue, lost and enable flag transitions and the input select range
  chk_lost_on_overflow: assert property ( // RQ6
    @(posedge clk) disable iff (rst)
    (state_q == EII_QUEUED && req && !unitDone && !lostWrite)
      |=> status.lost)
    else $error("overflow did not set lost");
  chk_lost_sticky: assert property ( // RQ7
    @(posedge clk) disable iff (rst)
    status.lost && !lostWrite |=> status.lost)
    else $error("lost cleared without a write");
  chk_lost_set_source: assert property ( // RQ7
    @(posedge clk) disable iff (rst)
    !status.lost && !(state_q == EII_QUEUED && req && !unitDone)
      |=> !status.lost)
    else $error("lost set without an overflow");
  chk_done_clears: assert property ( // RQ5
    @(posedge clk) disable iff (rst)
    (state_q == EII_ACTIVE && unitDone && !req) |=> !status.inService)
    else $error("in-service not cleared on completion");
  chk_event_starts: assert property ( // RQ4
    @(posedge clk) disable iff (rst)
    (state_q == EII_IDLE && req) |=> status.inService && unitStart)
    else $error("event did not start program unit");
  chk_queue_promote: assert property ( // RQ10
    @(posedge clk) disable iff (rst)
    (state_q == EII_QUEUED && unitDone && !req)
      |=> !status.queued && status.inService && unitStart)
    else $error("queued request not promoted");
  chk_queue_set: assert property ( // RQ8
    @(posedge clk) disable iff (rst)
    (state_q == EII_ACTIVE && req && !unitDone) |=> status.queued)
    else $error("queued flag not set");
  chk_auto_enable: assert property ( // RQ1
    @(posedge clk) disable iff (rst)
    (execMode && !execMode_q && autoStart_q) |=> status.channelEnable)
    else $error("auto start did not enable");
  chk_disabled_ignores: assert property ( // RQ9
    @(posedge clk) disable iff (rst)
    (!enable_q && state_q == EII_IDLE) |=> !unitStart)
    else $error("disabled channel started a unit");
  chk_sel_range: assert property ( // RQ2
    @(posedge clk) disable iff (rst)
    sel_q <= 4'(TOP_SEL) && $stable(sel_q) || !cfgLoaded_q
      || !$past(cfgLoaded_q))
    else $error("input select out of range or changed");

  cov_single: cover property (@(posedge clk) disable iff (rst)
    state_q == EII_IDLE ##1 state_q == EII_ACTIVE ##[1:20] state_q == EII_IDLE);
  cov_queue: cover property (@(posedge clk) disable iff (rst)
    state_q == EII_QUEUED ##[1:20] state_q == EII_ACTIVE);
  cov_lost: cover property (@(posedge clk) disable iff (rst)
    $rose(status.lost));
  cov_prog_clear: cover property (@(posedge clk) disable iff (rst)
    $fell(status.lost));
endmodule : eii_channel
`default_nettype wire

/* File: include/eii_pkg.sv */
// Behaviour
// (RQ1) Auto start set: enable flag is set whenever controller enters an executing mode; code ignores an execMode rise in the first cycle after reset.
// (RQ2) Input select binds channel to input 0..N, N = min(15, highest input).
// (RQ3) Input select and auto start are configuration only; program writes ignored.
// (RQ4) In-service flag set when valid event detected and program unit runs.
// (RQ5) In-service flag cleared when the program unit completes.
// (RQ6) One active, one queued request; a further request sets the lost flag.
// (RQ7) Only hardware sets lost; program may read it or write it to clear.
// (RQ8) Queued flag set while a request waits, cleared by hardware, read only.
// (RQ9) Read-only enable flag reports whether the channel is enabled.
// (RQ10) On completion with a queued request, promote it and keep in-service set.
`default_nettype none
package eii_pkg;
  localparam int unsigned EII_MAX_SEL = 15;
  localparam logic [3:0] EII_SEL_RESET = 4'h0;
  localparam logic EII_FLAG_RESET = 1'b0;

  typedef enum logic [2:0] {
    EII_IDLE = 3'b001,
    EII_ACTIVE = 3'b010,
    EII_QUEUED = 3'b100
  } eii_state_t;

  // Program-visible status word
  typedef struct packed {
    logic autoStart;
    logic channelEnable;
    logic inService;
    logic queued;
    logic lost;
  } eii_status_t;
endpackage : eii_pkg
`default_nettype wire

/* File: tb/eii_channel_tb_top.sv */
`default_nettype none
module eii_channel_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import eii_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic execMode;
  logic enSet;
  logic enClr;
  logic done;
  logic lostWr;
  logic lostDat;
  logic [15:0] cfgSel;
  logic cfgAs;
  logic unitStart;
  logic [15:0] pins;
  logic [15:0] selWord;
  eii_status_t st;
  int num_errors = 0;
  int samples_checked = 0;
  int starts = 0;

  // Clock and launch counter
  always #20 clk = ~clk;
  always @(negedge clk) if (unitStart === 1'b1) starts++;

  eii_channel #(.NUM_INPUTS(16)) eii_channel_inst (
    .clk(clk), .rst(rst), .fieldInputs(pins),
    .cfgInputSelect(cfgSel), .cfgAutoStart(cfgAs),
    .execMode(execMode), .enableSet(enSet), .enableClear(enClr),
    .unitDone(done), .lostWrite(lostWr), .lostWriteData(lostDat),
    .unitStart(unitStart), .inputSelectWord(selWord), .status(st));
  eii_field_dev eii_field_dev_inst (.clk(clk), .pins(pins));

  // ----------------------------------------
  // Compare, strobe and closing helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t word %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic check_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t flag %b exp %b", $time, got, exp);
    end
  endtask : check_flag

  task automatic strobe(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : strobe

  task automatic finish_test;
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_config;
    check(selWord, 16'h000F);
    check_flag(st.autoStart, 1'b1);
    check_flag(st.channelEnable, 1'b0);
    @(negedge clk);
    execMode = 1'b1;
    repeat (2) @(negedge clk);
    check_flag(st.channelEnable, 1'b1);
  endtask : t_config

  task automatic t_queue;
    eii_field_dev_inst.pulse(3);
    check(starts[15:0], 16'h0000);
    eii_field_dev_inst.pulse(15);
    check_flag(st.inService, 1'b1);
    eii_field_dev_inst.pulse(15);
    check_flag(st.queued, 1'b1);
    check_flag(st.lost, 1'b0);
    eii_field_dev_inst.pulse(15);
    check_flag(st.lost, 1'b1);
    strobe(done);
    check_flag(st.inService, 1'b1);
    check_flag(st.queued, 1'b0);
    check_flag(unitStart, 1'b1);
    @(negedge clk);
    check(starts[15:0], 16'h0002);
    strobe(done);
    check_flag(st.inService, 1'b0);
    check_flag(st.lost, 1'b1);
  endtask : t_queue

  task automatic t_lost_and_off;
    strobe(lostWr);
    check_flag(st.lost, 1'b0);
    lostDat = 1'b1;
    strobe(lostWr);
    check_flag(st.lost, 1'b0);
    strobe(enClr);
    check_flag(st.channelEnable, 1'b0);
    eii_field_dev_inst.pulse(15);
    check_flag(st.inService, 1'b0);
    strobe(enSet);
    check_flag(st.channelEnable, 1'b1);
  endtask : t_lost_and_off

  task automatic t_reconfig;
    @(negedge clk);
    rst = 1'b1;
    execMode = 1'b0;
    cfgSel = 16'h0003;
    cfgAs = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    check(selWord, 16'h0003);
    check_flag(st.autoStart, 1'b0);
    check_flag(st.channelEnable, 1'b0);
    cfgSel = 16'h0009;
    execMode = 1'b1;
    repeat (2) @(negedge clk);
    check(selWord, 16'h0003);
    check_flag(st.channelEnable, 1'b0);
    strobe(enSet);
    eii_field_dev_inst.pulse(15);
    check_flag(st.inService, 1'b0);
    eii_field_dev_inst.pulse(3);
    check_flag(st.inService, 1'b1);
    check(starts[15:0], 16'h0003);
    strobe(done);
    check_flag(st.inService, 1'b0);
  endtask : t_reconfig

  // Main sequence: reset, settle, run scenarios
  initial begin
    execMode = 1'b0;
    enSet = 1'b0;
    enClr = 1'b0;
    done = 1'b0;
    lostWr = 1'b0;
    lostDat = 1'b0;
    cfgSel = 16'h0014;
    cfgAs = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_config();
    t_queue();
    t_lost_and_off();
    t_reconfig();
    finish_test();
  end

  // Watchdog: the run needs about 83 cycles
  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
endmodule : eii_channel_tb_top
`default_nettype wire

/* File: tb/eii_field_dev.sv */
`default_nettype none
module eii_field_dev (
  input wire logic clk,
  output logic [15:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = 16'h0000;

  // ----------------------------------------
  // One field edge, then held low long enough to re-arm
  // ----------------------------------------
  task automatic pulse(input int idx);
    @(negedge clk);
    pins[idx] = 1'b1;
    repeat (3) @(negedge clk);
    pins[idx] = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse
endmodule : eii_field_dev
`default_nettype wire
